// ---- dv/sfsw_host.sv ----
/*
  Host-side model of the link: drives chip select, serial clock and data
  in, and captures the status stream at each rising serial clock edge.
  Assumes it is stepped from the bench clock, mode 0, idle clock low.
*/
module sfsw_host (
  input  wire logic i_clk,
  input  wire logic i_so,
  output      logic o_cs_n,
  output      logic o_sck,
  output      logic o_si
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] rd_q;
  int          hp;

  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_si   = 1'b0;
    rd_q   = 32'h0;
    hp     = 10;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // one frame: the low nbits of data, msb first
  // ----------------------------------------------------------------
  task automatic frame(input logic [39:0] data, input int nbits);
    o_cs_n = 1'b0;
    wait_clk(hp);
    for (int i = nbits - 1; i >= 0; i--) begin
      o_si = data[i];
      wait_clk(hp);
      o_sck = 1'b1;
      rd_q = {rd_q[30:0], i_so};
      wait_clk(hp);
      o_sck = 1'b0;
    end
    wait_clk(hp);
    o_cs_n = 1'b1;
    // a released data line must not keep looking valid
    o_si = ~o_si;
    wait_clk(10);
  endtask
endmodule

// ---- dv/sfsw_top_test.sv ----
/*
  Self-checking bench of the status write block: frames sent through the
  host model, same-clock pulses driven here, status bits compared.
  Assumes the design answers within a few clocks of chip select rising.
*/
module sfsw_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic       i_clk, i_rst, cs_n, sck, si, wp_n, busy, perr;
  logic       wset, wclr, rreq, so, so_oe, rbf, reset_cmd_enable, lock, prot, write_enable_latch, go;
  logic [7:0] sr2;
  logic       so_line;
  int         errors, checked, cyc, n;

  sfsw_top uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
    .i_wp_n(wp_n), .i_busy(busy), .i_prog_error(perr), .i_wel_set(wset),
    .i_wel_clr(wclr), .i_reset_req(rreq), .o_so(so), .o_so_oe(so_oe),
    .o_ready_busy_flag(rbf), .o_reset_cmd_enable(reset_cmd_enable),
    .o_protect_lock_bit(lock), .o_array_protect_bit(prot),
    .o_write_enable_latch(write_enable_latch), .o_status_second_byte(sr2),
    .o_reset_go(go)
  );

  // a released output line shows the inverse of its last level, so a
  // read sampled while the output is off cannot pass by accident
  assign so_line = so_oe ? so : ~so;

  sfsw_host host (
    .i_clk(i_clk), .i_so(so_line), .o_cs_n(cs_n), .o_sck(sck), .o_si(si)
  );

  initial i_clk = 1'b0;
  always #4 i_clk = ~i_clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wen();
    wset = 1'b1;
    tick(1);
    wset = 1'b0;
    tick(1);
  endtask

  // frame, then wait for the deselect to land
  task automatic fr(input logic [39:0] d, input int k);
    host.frame(d, k);
    tick(6);
  endtask

  // reset request pulse; counts cycles the go pulse stays high
  task automatic req(output int c);
    rreq = 1'b1;
    tick(1);
    rreq = 1'b0;
    c = 0;
    repeat (4) begin
      if (go === 1'b1) c++;
      tick(1);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {i_rst, wp_n} = 2'b11;
    {busy, perr, wset, wclr, rreq} = 5'h0;
    {errors, checked, cyc} = '0;
    tick(8);
    i_rst = 1'b0;
    tick(3);
    chk(32'({lock, prot, write_enable_latch, reset_cmd_enable, sr2}), 32'h0);
    $display("power-up test done");
    fr(40'h0184, 16);
    chk(32'({lock, prot, write_enable_latch}), 32'h0);
    wen();
    fr(40'h0184, 16);
    chk(32'({lock, prot, write_enable_latch}), 32'h6);
    wen();
    wp_n = 1'b0;
    fr(40'h0100, 16);
    chk(32'({lock, prot, write_enable_latch}), 32'h6);
    wen();
    fr(40'h0180, 16);
    chk(32'({lock, prot, write_enable_latch}), 32'h6);
    wen();
    wp_n = 1'b1;
    fr(40'h0100FF, 24);
    chk(32'({lock, prot, write_enable_latch}), 32'h0);
    $display("protection write tests done");
    wen();
    fr(40'h01840, 20);
    chk(32'({lock, prot, write_enable_latch}), 32'h0);
    wen();
    fr(40'h018, 12);
    chk(32'({lock, prot, write_enable_latch}), 32'h0);
    wen();
    fr(40'h01, 8);
    chk(32'({lock, prot, write_enable_latch}), 32'h0);
    wen();
    fr(40'h00, 5);
    chk(32'(write_enable_latch), 32'h1);
    $display("abort tests done");
    fr(40'h3110, 16);
    chk(32'({reset_cmd_enable, write_enable_latch, sr2}), 32'h210);
    busy = 1'b1;
    tick(3);
    chk(32'({rbf, sr2}), 32'h111);
    busy = 1'b0;
    req(n);
    chk(32'(n), 32'h1);
    chk(32'(reset_cmd_enable), 32'h1);
    wen();
    fr(40'h31EF, 16);
    chk(32'({reset_cmd_enable, write_enable_latch, sr2}), 32'h0);
    req(n);
    chk(32'(n), 32'h0);
    wen();
    fr(40'h31100, 20);
    chk(32'({reset_cmd_enable, write_enable_latch}), 32'h0);
    wen();
    fr(40'h3110EF, 24);
    chk(32'({reset_cmd_enable, write_enable_latch}), 32'h2);
    $display("second byte write tests done");
    wen();
    perr = 1'b1;
    busy = 1'b1;
    fork
      host.frame(40'h0500000000, 40);
      begin
        tick(250);
        busy = 1'b0;
        chk(32'(so_oe), 32'h1);
      end
    join
    // first byte shows busy, later bytes show it fallen
    chk(host.rd_q, 32'h33103210);
    chk(32'(so_oe), 32'h0);
    $display("status read test done");
    // set beats a clear in the same cycle; a lone clear still clears
    wset = 1'b1;
    wclr = 1'b1;
    tick(1);
    {wset, wclr} = 2'h0;
    tick(1);
    chk(32'(write_enable_latch), 32'h1);
    wclr = 1'b1;
    tick(1);
    wclr = 1'b0;
    tick(1);
    chk(32'(write_enable_latch), 32'h0);
    // a mid-run reset clears the enable and the latch again
    wen();
    i_rst = 1'b1;
    tick(3);
    i_rst = 1'b0;
    tick(3);
    chk(32'({reset_cmd_enable, write_enable_latch, sr2}), 32'h0);
    $display("latch and reset tests done");
    complete_run();
  end
endmodule

// ---- rtl/sfsw_pkg.sv ----
/*
  Shared constants and types of the serial flash status-write block:
  opcodes, status bit positions, reset values, pin carrier and states.
  Assumes a single 125 MHz clock domain that oversamples the link pins.
*/
package sfsw_pkg;

  // ----------------------------------------------------------------
  // command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ_STATUS  = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_WRITE_SR2    = 8'h31;

  // ----------------------------------------------------------------
  // status byte field positions
  // ----------------------------------------------------------------
  localparam int LOCK_POS  = 7;
  localparam int EPE_POS   = 5;
  localparam int WPP_POS   = 4;
  localparam int PROT_POS  = 2;
  localparam int WEL_POS   = 1;
  localparam int BUSY_POS  = 0;
  localparam int RESET_CMD_ENABLE_POS  = 4;

  // reserved bits of status byte 2 read as zero
  localparam logic [7:0] SR2_RSVD_MASK = 8'hEE;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic       RST_LOCK = 1'b0;
  localparam logic       RST_PROT = 1'b0;
  localparam logic       RST_WEL  = 1'b0;
  localparam logic       RST_RESET_CMD_ENABLE = 1'b0;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [1:0] BYTES_FULL = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } sfsw_pins_t;

  // idle pin levels: deselected, clock low, not write-protected
  localparam sfsw_pins_t RST_PINS = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0,
                                      wp_n: 1'b1};

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_READ,
    ST_WSR1,
    ST_WSR2,
    ST_SKIP
  } sfsw_state_t;

endpackage

// ---- rtl/sfsw_sync.sv ----
/*
  Two-flop synchroniser for the link pins.
  Assumes the pins are asynchronous to i_clk; only stage two is read.
*/
module sfsw_sync (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire sfsw_pkg::sfsw_pins_t i_pins,
  output      sfsw_pkg::sfsw_pins_t o_pins
);

  typedef struct packed {
    sfsw_pkg::sfsw_pins_t s1;
    sfsw_pkg::sfsw_pins_t s2;
  } sfsw_sync_st_t;

  sfsw_sync_st_t r;
  sfsw_sync_st_t r_nxt;

  always_comb begin
    r_nxt    = r;
    r_nxt.s1 = i_pins;
    r_nxt.s2 = r.s1;
  end

  // reset to the idle pin levels so no false edge follows reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r <= '{s1: sfsw_pkg::RST_PINS, s2: sfsw_pkg::RST_PINS};
    end else begin
      r <= r_nxt;
    end
  end

  assign o_pins = r.s2;

endmodule

// ---- rtl/sfsw_top.sv ----
/*
  Status register logic of a small serial flash: status read, the
  protection write, the status byte 2 write and reset-command gating.
  Assumes SPI mode 0 or 3 pins oversampled by i_clk, and that other
  command logic on i_clk pulses write-enable set/clear and reset request.
*/

// Operation
// - busy flag appears at bit 0 of both status bytes.
// - reset enable clears at power-up; reset requests ignored while zero.
// - reset requests are acted on while reset-command enable is one.
// - reset-command enable changes only by status byte 2 write or power.
// - status byte 2 holds enable at bit 4, busy at 0, zeros elsewhere.
// - protection write is 01h plus one byte: bit 7 lock, bit 2 protect.
// - bytes after the protection write data byte are discarded.
// - valid protection write updates lock and protect, clears the latch.
// - outcome depends on data, prior lock and write-protect pin at deselect.
// - short or off-boundary protection write aborts, latch still cleared.
// - with write-protect asserted, a lock clear is ignored, latch cleared.
// - status byte 2 write is 31h plus one byte, bit 4 enable.
// - status byte 2 write alone changes the enable; latch required first.
// - bytes after the status byte 2 write data byte are discarded.
// - valid status byte 2 write loads enable and clears the latch.
// - short or off-boundary status byte 2 write keeps enable, clears latch.
// - status writes are refused while the write-enable latch is zero.
// - lock set and write-protect asserted freezes the protect bit.
// - status read after 05h streams byte 1 then byte 2, MSB first.
// - an incomplete opcode at deselect leaves the latch unchanged.
module sfsw_top (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_cs_n,
  input  wire logic i_sck,
  input  wire logic i_si,
  input  wire logic i_wp_n,
  input  wire logic i_busy,
  input  wire logic i_prog_error,
  input  wire logic i_wel_set,
  input  wire logic i_wel_clr,
  input  wire logic i_reset_req,
  output      logic o_so,
  output      logic o_so_oe,
  output      logic o_ready_busy_flag,
  output      logic o_reset_cmd_enable,
  output      logic o_protect_lock_bit,
  output      logic o_array_protect_bit,
  output      logic o_write_enable_latch,
  output      logic [7:0] o_status_second_byte,
  output      logic o_reset_go
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    sfsw_pkg::sfsw_state_t state;
    logic                  cs_prev;
    logic                  sck_prev;
    logic [2:0]            bit_idx;
    logic [1:0]            byte_cnt;
    logic [7:0]            shift_in;
    logic [7:0]            data_byte;
    logic [7:0]            out_sh;
    logic [2:0]            out_cnt;
    logic                  out_sel;
    logic                  so;
    logic                  so_oe;
    logic                  lock;
    logic                  prot;
    logic                  reset_cmd_enable;
    logic                  write_enable_latch;
    logic                  busy;
    logic                  epe;
    logic                  reset_go;
    logic [7:0]            sr2;
  } sfsw_top_st_t;

  sfsw_top_st_t         r;
  sfsw_top_st_t         r_nxt;
  sfsw_pkg::sfsw_pins_t pins_raw;
  sfsw_pkg::sfsw_pins_t pins;

  assign pins_raw = '{cs_n: i_cs_n, sck: i_sck, si: i_si, wp_n: i_wp_n};

  // every pin passes two flops; edge detectors read only the second
  sfsw_sync u_sync (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_pins (pins_raw),
    .o_pins (pins)
  );

  // ----------------------------------------------------------------
  // pin events and status images
  // ----------------------------------------------------------------
  logic       cs_fall;
  logic       cs_rise;
  logic       sck_rise;
  logic       sck_fall;
  logic       byte_done;
  logic       frame_full;
  logic       wp_on;
  logic [7:0] byte_in;
  logic [7:0] sr1_img;
  logic [7:0] sr2_img;

  assign cs_fall    = !pins.cs_n && r.cs_prev;
  assign cs_rise    = pins.cs_n && !r.cs_prev && (r.state != sfsw_pkg::ST_IDLE);
  assign sck_rise   = !pins.cs_n && pins.sck && !r.sck_prev;
  assign sck_fall   = !pins.cs_n && !pins.sck && r.sck_prev;
  assign byte_in    = {r.shift_in[6:0], pins.si};
  assign byte_done  = sck_rise && (r.bit_idx == sfsw_pkg::BIT_LAST);
  // a whole data byte and a deselect on a byte boundary
  assign frame_full = (r.byte_cnt == sfsw_pkg::BYTES_FULL)
                   && (r.bit_idx == 3'h0);
  assign wp_on      = !pins.wp_n;

  always_comb begin
    sr1_img                     = sfsw_pkg::RST_BYTE;
    sr1_img[sfsw_pkg::LOCK_POS] = r.lock;
    sr1_img[sfsw_pkg::EPE_POS]  = r.epe;
    sr1_img[sfsw_pkg::WPP_POS]  = pins.wp_n;
    sr1_img[sfsw_pkg::PROT_POS] = r.prot;
    sr1_img[sfsw_pkg::WEL_POS]  = r.write_enable_latch;
    sr1_img[sfsw_pkg::BUSY_POS] = r.busy;
    sr2_img                     = sfsw_pkg::RST_BYTE;
    sr2_img[sfsw_pkg::RESET_CMD_ENABLE_POS] = r.reset_cmd_enable;
    sr2_img[sfsw_pkg::BUSY_POS] = r.busy;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_nxt          = r;
    r_nxt.cs_prev  = pins.cs_n;
    r_nxt.sck_prev = pins.sck;
    r_nxt.busy     = i_busy;
    r_nxt.epe      = i_prog_error;
    r_nxt.sr2      = sr2_img;
    // the enable only gates the request; it is never touched by it
    r_nxt.reset_go = i_reset_req && r.reset_cmd_enable;

    if (cs_fall) begin
      r_nxt.state    = sfsw_pkg::ST_CMD;
      r_nxt.bit_idx  = 3'h0;
      r_nxt.byte_cnt = 2'h0;
      r_nxt.so_oe    = 1'b0;
    end else if (cs_rise) begin
      r_nxt.state = sfsw_pkg::ST_IDLE;
      r_nxt.so_oe = 1'b0;
      r_nxt.so    = 1'b0;
      unique case (r.state)
        sfsw_pkg::ST_WSR1: begin
          if (frame_full) begin
            // clearing the lock under write-protect drops the command
            if (!(wp_on && r.lock &&
                  !r.data_byte[sfsw_pkg::LOCK_POS])) begin
              r_nxt.lock = r.data_byte[sfsw_pkg::LOCK_POS];
              if (!(wp_on && r.lock)) begin
                r_nxt.prot = r.data_byte[sfsw_pkg::PROT_POS];
              end
            end
          end
          r_nxt.write_enable_latch = 1'b0;
        end
        sfsw_pkg::ST_WSR2: begin
          if (frame_full) begin
            r_nxt.reset_cmd_enable = r.data_byte[sfsw_pkg::RESET_CMD_ENABLE_POS];
          end
          r_nxt.write_enable_latch = 1'b0;
        end
        // an unfinished opcode keeps the latch as it stands
        sfsw_pkg::ST_CMD:  r_nxt.write_enable_latch = r.write_enable_latch;
        sfsw_pkg::ST_READ: r_nxt.write_enable_latch = r.write_enable_latch;
        sfsw_pkg::ST_SKIP: r_nxt.write_enable_latch = r.write_enable_latch;
        sfsw_pkg::ST_IDLE: r_nxt.write_enable_latch = r.write_enable_latch;
      endcase
    end else if (r.state != sfsw_pkg::ST_IDLE) begin
      if (sck_rise) begin
        r_nxt.shift_in = byte_in;
        r_nxt.bit_idx  = r.bit_idx + 3'h1;
      end
      if (byte_done) begin
        if (r.byte_cnt != sfsw_pkg::BYTES_FULL) begin
          r_nxt.byte_cnt = r.byte_cnt + 2'h1;
        end
        // only the first byte after the opcode is kept
        if (r.byte_cnt == 2'h1) begin
          r_nxt.data_byte = byte_in;
        end
        if (r.state == sfsw_pkg::ST_CMD) begin
          unique case (byte_in)
            sfsw_pkg::OP_READ_STATUS: begin
              r_nxt.state   = sfsw_pkg::ST_READ;
              r_nxt.out_sh  = sr1_img;
              r_nxt.out_cnt = 3'h0;
              r_nxt.out_sel = 1'b1;
              r_nxt.so_oe   = 1'b1;
            end
            sfsw_pkg::OP_WRITE_STATUS: begin
              r_nxt.state = r.write_enable_latch ? sfsw_pkg::ST_WSR1
                                  : sfsw_pkg::ST_SKIP;
            end
            sfsw_pkg::OP_WRITE_SR2: begin
              r_nxt.state = r.write_enable_latch ? sfsw_pkg::ST_WSR2
                                  : sfsw_pkg::ST_SKIP;
            end
            default: r_nxt.state = sfsw_pkg::ST_SKIP;
          endcase
        end
      end
      if (sck_fall && (r.state == sfsw_pkg::ST_READ)) begin
        r_nxt.so      = r.out_sh[7];
        r_nxt.out_cnt = r.out_cnt + 3'h1;
        if (r.out_cnt == sfsw_pkg::BIT_LAST) begin
          // reload from live state so each pass shows fresh data
          r_nxt.out_sh  = r.out_sel ? sr2_img : sr1_img;
          r_nxt.out_sel = !r.out_sel;
        end else begin
          r_nxt.out_sh = {r.out_sh[6:0], 1'b0};
        end
      end
    end

    // the other command logic wins over a deselect clear in one cycle
    if (i_wel_clr) begin
      r_nxt.write_enable_latch = 1'b0;
    end
    if (i_wel_set) begin
      r_nxt.write_enable_latch = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r           <= '0;
      r.state     <= sfsw_pkg::ST_IDLE;
      r.cs_prev   <= 1'b1;
      r.lock      <= sfsw_pkg::RST_LOCK;
      r.prot      <= sfsw_pkg::RST_PROT;
      r.write_enable_latch       <= sfsw_pkg::RST_WEL;
      r.reset_cmd_enable      <= sfsw_pkg::RST_RESET_CMD_ENABLE;
      r.data_byte <= sfsw_pkg::RST_BYTE;
    end else begin
      r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_so                 = r.so;
  assign o_so_oe              = r.so_oe;
  assign o_ready_busy_flag    = r.busy;
  assign o_reset_cmd_enable   = r.reset_cmd_enable;
  assign o_protect_lock_bit   = r.lock;
  assign o_array_protect_bit  = r.prot;
  assign o_write_enable_latch = r.write_enable_latch;
  assign o_status_second_byte = r.sr2;
  assign o_reset_go           = r.reset_go;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic wsr1_end;
  logic wsr2_end;
  assign wsr1_end = cs_rise && (r.state == sfsw_pkg::ST_WSR1);
  assign wsr2_end = cs_rise && (r.state == sfsw_pkg::ST_WSR2);

  a_busy_both: assert property (
    ##1 (o_ready_busy_flag == $past(i_busy)) ##1
    (o_status_second_byte[sfsw_pkg::BUSY_POS] == $past(i_busy, 2)))
    else $error("busy flag not shown in both bytes");
  a_sr2_reserved: assert property (
    (o_status_second_byte & sfsw_pkg::SR2_RSVD_MASK) == 8'h00)
    else $error("reserved status byte 2 bits not zero");
  a_reset_gated: assert property (
    i_reset_req && !o_reset_cmd_enable |=> !o_reset_go)
    else $error("reset accepted while disabled");
  a_reset_taken: assert property (
    i_reset_req && o_reset_cmd_enable |=> o_reset_go)
    else $error("reset refused while enabled");
  a_reset_cmd_enable_source: assert property (
    $changed(o_reset_cmd_enable) |-> $past(wsr2_end && frame_full))
    else $error("reset enable changed outside its write");
  a_wsr2_load: assert property (
    wsr2_end && !i_wel_set |=> !o_write_enable_latch &&
    (o_reset_cmd_enable == $past(frame_full ?
      r.data_byte[sfsw_pkg::RESET_CMD_ENABLE_POS] : o_reset_cmd_enable)))
    else $error("status byte 2 write result wrong");
  a_wsr1_abort: assert property (
    wsr1_end && !frame_full && !i_wel_set |=>
    $stable(o_protect_lock_bit) && $stable(o_array_protect_bit) &&
    !o_write_enable_latch)
    else $error("aborted protection write changed state");
  a_lock_clear_wp: assert property (
    wsr1_end && wp_on && o_protect_lock_bit |=>
    o_protect_lock_bit && $stable(o_array_protect_bit))
    else $error("locked state changed under write-protect");
  a_opcode_short: assert property (
    cs_rise && (r.state == sfsw_pkg::ST_CMD) && !i_wel_clr &&
    !i_wel_set |=>
    o_write_enable_latch == $past(o_write_enable_latch))
    else $error("latch changed by incomplete opcode");
  a_refuse_nowel: assert property (
    byte_done && (r.state == sfsw_pkg::ST_CMD) && !r.write_enable_latch &&
    (byte_in == sfsw_pkg::OP_WRITE_STATUS ||
     byte_in == sfsw_pkg::OP_WRITE_SR2) |=>
    r.state == sfsw_pkg::ST_SKIP)
    else $error("status write taken without latch");
  // the ones below watch the deselect outcomes, the read enable and the byte 2 image,
  // so a broken refusal or a stuck output enable shows up at once
  a_wsr1_load: assert property (
    wsr1_end && frame_full && !wp_on && !i_wel_set |=>
    !o_write_enable_latch &&
    (o_protect_lock_bit == $past(r.data_byte[sfsw_pkg::LOCK_POS])) &&
    (o_array_protect_bit == $past(r.data_byte[sfsw_pkg::PROT_POS])))
    else $error("valid protection write not applied");
  a_skip_keeps: assert property (
    cs_rise && (r.state == sfsw_pkg::ST_SKIP) |=>
    $stable(o_protect_lock_bit) && $stable(o_array_protect_bit) &&
    $stable(o_reset_cmd_enable))
    else $error("refused write changed status bits");
  a_so_enable: assert property (
    o_so_oe |-> (r.state == sfsw_pkg::ST_READ))
    else $error("output driven outside a status read");
  a_so_release: assert property (
    cs_rise |=> !o_so_oe)
    else $error("output still driven after deselect");
  a_sr2_image: assert property (
    ##1 (o_status_second_byte[sfsw_pkg::RESET_CMD_ENABLE_POS] ==
         $past(o_reset_cmd_enable)))
    else $error("status byte 2 enable bit out of step");

  c_read: cover property (r.state == sfsw_pkg::ST_READ && sck_fall &&
                          r.out_cnt == sfsw_pkg::BIT_LAST && !r.out_sel);
  c_wsr1: cover property (wsr1_end && frame_full && !wp_on);
  c_wsr1_wp: cover property (wsr1_end && frame_full && wp_on && r.lock);
  c_wsr2: cover property (wsr2_end && frame_full);
  c_abort: cover property (wsr2_end && !frame_full);

endmodule
